// file: hdl/sfs_pkg.sv
package sfs_pkg;

	// ==========================================================
	// Register indices and reset values
	localparam logic [7:0] PIN_FLOPPY_IDX    = 8'h03;
	localparam logic [7:0] PORT_EXT_IDX      = 8'h04;
	localparam logic [7:0] PIN_FLOPPY_RESET  = 8'h70;
	localparam logic [7:0] PORT_EXT_RESET    = 8'h00;
	localparam logic [7:0] LOCKED_IDX_LAST   = 8'h2F;
	// Writable bits; reserved bits read zero
	localparam logic [7:0] PIN_FLOPPY_WMASK  = 8'hF7;
	localparam logic [7:0] PORT_EXT_WMASK    = 8'h7F;

	// ==========================================================
	// Field positions, pin and floppy setup
	localparam int PF_GAME_SEL_BIT   = 0;
	localparam int PF_ENH_FLOPPY_BIT = 1;
	localparam int PF_IRQ_SEL_BIT    = 2;
	localparam int PF_DENSITY_BIT    = 4;
	localparam int PF_MODULATION_BIT = 5;
	localparam int PF_IDENT_BIT      = 6;
	localparam int PF_PIN2_SEL_BIT   = 7;

	// Field positions, port extended setup
	localparam int PE_PAR_MODE_LSB   = 0;
	localparam int PE_PFD_LSB        = 2;
	localparam int PE_UART1_MIDI_BIT = 4;
	localparam int PE_UART2_MIDI_BIT = 5;
	localparam int PE_EPP_TYPE_BIT   = 6;

	// ==========================================================
	// Baud prescaler divisors (reference ticks per output tick)
	localparam logic [3:0] DIV_NORMAL  = 4'hD;
	localparam logic [3:0] DIV_MIDI    = 4'hC;
	localparam logic [3:0] DIV_CNT_RST = 4'h0;

	// ==========================================================
	// Modes
	typedef enum logic [1:0]
	{
		FLOPPY_IF_COMPACT   = 2'b00,
		FLOPPY_IF_ALTERNATE = 2'b01,
		FLOPPY_IF_RESERVED  = 2'b10,
		FLOPPY_IF_HOST      = 2'b11
	} sfs_floppy_if_e;

	typedef enum logic [2:0]
	{
		PAR_PRINTER  = 3'b100,
		PAR_SPP_BIDI = 3'b000,
		PAR_EPP_SPP  = 3'b001,
		PAR_ECP      = 3'b010,
		PAR_ECP_EPP  = 3'b011
	} sfs_par_mode_e;

	typedef enum logic [1:0]
	{
		PFD_NORMAL   = 2'b00,
		PFD_VARIANT1 = 2'b01,
		PFD_VARIANT2 = 2'b10,
		PFD_RESERVED = 2'b11
	} sfs_pfd_e;

	typedef enum logic [1:0]
	{
		SHARED_PIN2_IN   = 2'b00,
		SHARED_ADDR_QUAL = 2'b01,
		SHARED_IRQ_OUT   = 2'b10
	} sfs_shared_fn_e;

	// ==========================================================
	// Carriers
	typedef struct packed
	{
		logic       cfg_state;
		logic [7:0] config_index_reg;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfs_cfg_req_s;

	typedef struct packed
	{
		logic           game_port_mode;
		logic           enhanced_floppy;
		sfs_floppy_if_e floppy_if;
		sfs_shared_fn_e shared_fn;
		sfs_par_mode_e  par_mode;
		sfs_pfd_e       port_floppy;
		logic           epp_v17;
		logic           uart1_midi;
		logic           uart2_midi;
	} sfs_setup_s;

	typedef struct packed
	{
		logic [7:0] pin_floppy_setup;
		logic [7:0] port_extended_setup;
		logic [7:0] rdata;
		logic [1:0] pg_sync;
		logic [1:0] pin2_sync;
		logic [3:0] div1_cnt;
		logic [3:0] div2_cnt;
		logic       tick1;
		logic       tick2;
		logic       density;
		sfs_setup_s setup;
	} sfs_state_s;

endpackage

// file: hdl/sfs_setup_regs.sv
`timescale 1ns/1ps
// What this block does
// (R01) Pin/floppy register reachable in config state, index 03H
// (R02) Pin/floppy register resets to 70H
// (R03) Port extended register reachable in config state, index 04H
// (R04) Port extended register resets to 00H
// (R05) Bit 1 selects normal or enhanced floppy mode
// (R06) Bit 4 forces second density output high
// (R07) Bits 6:5 select floppy interface mode
// (R08) Extended parallel field applies only when mode bit low
// (R09) Bits 1:0 select parallel extended modes
// (R10) Bits 3:2 select floppy-on-parallel-port option
// (R11) Bit 4 sets first UART divide 13/12
// (R12) Bit 5 sets second UART divide 13/12
// (R13) Bit 6 selects EPP version 1.9/1.7
// (R14) Mode bit high runs parallel port as printer
// (R15) Cleared lock bit blocks config registers 00-2F
// (R16) Divide-by-12 gives MIDI rate from reference
// (R17) Bit 0 selects power-good input or game select
// (R18) Bits 7,2 select drive-2, address or interrupt
// (R19) Reserved bits read zero, writes ignored
module sfs_setup_regs
(
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	input  wire sfs_pkg::sfs_cfg_req_s cfg_req,
	output logic [7:0]                cfg_rdata,
	input  wire logic                 printer_mode_bit,
	input  wire logic                 lock_enable,
	input  wire logic                 baud_ref_tick,
	input  wire logic                 programmed_density,
	output logic                      second_density_out,
	input  wire logic                 power_good_pin_in,
	input  wire logic                 game_port_select,
	output logic                      shared_pin_out,
	output logic                      shared_pin_oe_n,
	output logic                      power_good_input,
	input  wire logic                 second_drive_pin_in,
	input  wire logic                 extra_irq,
	output logic                      address_qual_pin,
	output logic                      second_drive_pin_out,
	output logic                      second_drive_pin_oe_n,
	output logic                      second_drive_present,
	output logic                      uart1_baud_tick,
	output logic                      uart2_baud_tick,
	output sfs_pkg::sfs_setup_s       setup
);

	// ==========================================================
	// State
	sfs_pkg::sfs_state_s state_q;
	sfs_pkg::sfs_state_s state_d;

	logic       access_ok;
	logic       sel_pf;
	logic       sel_pe;
	logic [7:0] pf;
	logic [7:0] pe;

	// ==========================================================
	// Access decode
	// Lock only covers the low index range; both our indices are in it
	always_comb
	begin
		access_ok = cfg_req.cfg_state
			&& !(!lock_enable && cfg_req.config_index_reg <= sfs_pkg::LOCKED_IDX_LAST); // see (R15)
		sel_pf = access_ok && cfg_req.config_index_reg == sfs_pkg::PIN_FLOPPY_IDX; // see (R01)
		sel_pe = access_ok && cfg_req.config_index_reg == sfs_pkg::PORT_EXT_IDX;   // see (R03)
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		state_d = state_q;
		pf = state_q.pin_floppy_setup;
		pe = state_q.port_extended_setup;

		// Register writes; reserved bits masked away
		if (cfg_req.wr && sel_pf)
		begin
			state_d.pin_floppy_setup = cfg_req.wdata & sfs_pkg::PIN_FLOPPY_WMASK; // see (R19)
		end
		if (cfg_req.wr && sel_pe)
		begin
			state_d.port_extended_setup = cfg_req.wdata & sfs_pkg::PORT_EXT_WMASK; // see (R19)
		end

		// Read data is held until the next read; blocked reads return zero
		if (cfg_req.rd)
		begin
			if (sel_pf)
			begin
				state_d.rdata = pf & sfs_pkg::PIN_FLOPPY_WMASK; // see (R01)
			end
			else if (sel_pe)
			begin
				state_d.rdata = pe & sfs_pkg::PORT_EXT_WMASK; // see (R03)
			end
			else
			begin
				state_d.rdata = 8'h00; // see (R15)
			end
		end

		// Pin synchronisers; only the second stage feeds logic
		state_d.pg_sync   = {state_q.pg_sync[0], power_good_pin_in};
		state_d.pin2_sync = {state_q.pin2_sync[0], second_drive_pin_in};

		// Decoded floppy-side setup
		state_d.setup.game_port_mode  = pf[sfs_pkg::PF_GAME_SEL_BIT];   // see (R17)
		state_d.setup.enhanced_floppy = pf[sfs_pkg::PF_ENH_FLOPPY_BIT]; // see (R05)
		state_d.setup.floppy_if = sfs_pkg::sfs_floppy_if_e'(
			{pf[sfs_pkg::PF_IDENT_BIT], pf[sfs_pkg::PF_MODULATION_BIT]}); // see (R07)

		// Shared pin: bit 7 low means drive-2 input regardless of bit 2
		if (!pf[sfs_pkg::PF_PIN2_SEL_BIT])
		begin
			state_d.setup.shared_fn = sfs_pkg::SHARED_PIN2_IN; // see (R18)
		end
		else if (pf[sfs_pkg::PF_IRQ_SEL_BIT])
		begin
			state_d.setup.shared_fn = sfs_pkg::SHARED_IRQ_OUT; // see (R18)
		end
		else
		begin
			state_d.setup.shared_fn = sfs_pkg::SHARED_ADDR_QUAL; // see (R18)
		end

		// Forced-high density unless bit 4 is clear
		state_d.density = pf[sfs_pkg::PF_DENSITY_BIT] ? 1'b1 : programmed_density; // see (R06)

		// Parallel mode: extended field only counts with mode bit low
		if (printer_mode_bit)
		begin
			state_d.setup.par_mode = sfs_pkg::PAR_PRINTER; // see (R14)
		end
		else
		begin
			state_d.setup.par_mode = sfs_pkg::sfs_par_mode_e'(
				{1'b0, pe[sfs_pkg::PE_PAR_MODE_LSB +: 2]}); // see (R08) see (R09)
		end
		state_d.setup.port_floppy = sfs_pkg::sfs_pfd_e'(pe[sfs_pkg::PE_PFD_LSB +: 2]); // see (R10)
		state_d.setup.epp_v17     = pe[sfs_pkg::PE_EPP_TYPE_BIT];   // see (R13)
		state_d.setup.uart1_midi  = pe[sfs_pkg::PE_UART1_MIDI_BIT]; // see (R11)
		state_d.setup.uart2_midi  = pe[sfs_pkg::PE_UART2_MIDI_BIT]; // see (R12)

		// Baud prescalers on the reference tick, 13 or 12 per output
		state_d.tick1 = 1'b0;
		state_d.tick2 = 1'b0;
		if (baud_ref_tick)
		begin
			if (state_q.div1_cnt >= (pe[sfs_pkg::PE_UART1_MIDI_BIT] ?
				sfs_pkg::DIV_MIDI : sfs_pkg::DIV_NORMAL) - 4'h1) // see (R11) see (R16)
			begin
				state_d.div1_cnt = sfs_pkg::DIV_CNT_RST;
				state_d.tick1 = 1'b1;
			end
			else
			begin
				state_d.div1_cnt = state_q.div1_cnt + 4'h1;
			end
			if (state_q.div2_cnt >= (pe[sfs_pkg::PE_UART2_MIDI_BIT] ?
				sfs_pkg::DIV_MIDI : sfs_pkg::DIV_NORMAL) - 4'h1) // see (R12) see (R16)
			begin
				state_d.div2_cnt = sfs_pkg::DIV_CNT_RST;
				state_d.tick2 = 1'b1;
			end
			else
			begin
				state_d.div2_cnt = state_q.div2_cnt + 4'h1;
			end
		end
	end

	// ==========================================================
	// State register; reset values are the power-up defaults
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= '0;
			state_q.pin_floppy_setup    <= sfs_pkg::PIN_FLOPPY_RESET; // see (R02)
			state_q.port_extended_setup <= sfs_pkg::PORT_EXT_RESET;   // see (R04)
			state_q.density             <= 1'b1;
			state_q.setup.floppy_if     <= sfs_pkg::FLOPPY_IF_HOST;
			state_q.setup.par_mode      <= sfs_pkg::PAR_PRINTER;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Outputs
	// Shared pin one: game select drives, power-good is input only
	always_comb
	begin
		cfg_rdata          = state_q.rdata;
		setup              = state_q.setup;
		second_density_out = state_q.density; // see (R06)
		uart1_baud_tick    = state_q.tick1;
		uart2_baud_tick    = state_q.tick2;

		shared_pin_out   = game_port_select;
		shared_pin_oe_n  = !state_q.setup.game_port_mode; // see (R17)
		power_good_input = state_q.setup.game_port_mode ? 1'b1 : state_q.pg_sync[1];

		// Pin two: input for drive-2 or address, driven for interrupt
		second_drive_pin_out  = extra_irq;
		second_drive_pin_oe_n = state_q.setup.shared_fn != sfs_pkg::SHARED_IRQ_OUT; // see (R18)
		second_drive_present  = state_q.setup.shared_fn == sfs_pkg::SHARED_PIN2_IN
			&& state_q.pin2_sync[1];
		address_qual_pin      = state_q.setup.shared_fn == sfs_pkg::SHARED_ADDR_QUAL
			&& state_q.pin2_sync[1];
	end

endmodule

// file: verification/sfs_setup_regs_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks of the setup registers
module sfs_setup_regs_chk
(
	input wire logic                  clock,
	input wire logic                  sys_rst,
	input wire sfs_pkg::sfs_cfg_req_s cfg_req,
	input wire logic [7:0]            cfg_rdata,
	input wire logic                  printer_mode_bit,
	input wire logic                  lock_enable,
	input wire logic                  second_density_out,
	input wire logic                  shared_pin_oe_n,
	input wire logic                  second_drive_pin_oe_n,
	input wire sfs_pkg::sfs_setup_s   setup
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// Accepted writes and a refused read; both indices sit under the lock
	sequence s_pf_wr;
		cfg_req.wr && cfg_req.cfg_state && lock_enable && cfg_req.config_index_reg == 8'h03;
	endsequence
	sequence s_pe_wr;
		cfg_req.wr && cfg_req.cfg_state && lock_enable && cfg_req.config_index_reg == 8'h04;
	endsequence
	sequence s_bad_rd;
		cfg_req.rd && !(cfg_req.cfg_state && lock_enable);
	endsequence

	// Decoded fields land two edges after the write
	a_pf_fields: assert property (
		s_pf_wr |-> ##2 setup.floppy_if == $past(cfg_req.wdata[6:5], 2)
		&& setup.enhanced_floppy == $past(cfg_req.wdata[1], 2)) else $error("pin fields wrong");
	a_density_forced: assert property (
		s_pf_wr ##0 cfg_req.wdata[4] |-> ##2 second_density_out) else $error("density not high");
	a_pe_fields: assert property (
		s_pe_wr |-> ##2 {setup.epp_v17, setup.uart2_midi, setup.uart1_midi, setup.port_floppy}
		== $past(cfg_req.wdata[6:2], 2)) else $error("port fields wrong");
	a_par_extended: assert property (
		s_pe_wr ##1 !printer_mode_bit |=> setup.par_mode == {1'b0, $past(cfg_req.wdata[1:0], 2)})
		else $error("parallel mode wrong");
	a_printer_mode: assert property (
		printer_mode_bit |=> setup.par_mode == sfs_pkg::PAR_PRINTER) else $error("not printer");
	// Enables follow the decoded setup, so two edges after the write
	a_pin_enables: assert property (
		s_pf_wr |-> ##2 shared_pin_oe_n == !$past(cfg_req.wdata[0], 2) && second_drive_pin_oe_n
		== !($past(cfg_req.wdata[7], 2) && $past(cfg_req.wdata[2], 2)))
		else $error("pin enable wrong");
	a_blocked_read: assert property (
		s_bad_rd |=> cfg_rdata == 8'h00) else $error("blocked read not zero");
	a_reserved_zero: assert property (
		cfg_req.rd && cfg_req.config_index_reg == 8'h03 |=> !cfg_rdata[3]) else $error("bit 3 set");
endmodule

bind sfs_setup_regs sfs_setup_regs_chk u_chk
(
	.clock, .sys_rst, .cfg_req, .cfg_rdata, .printer_mode_bit, .lock_enable,
	.second_density_out, .shared_pin_oe_n, .second_drive_pin_oe_n, .setup
);

// file: verification/test_sfs_setup_regs.sv
`timescale 1ns/1ps
module test_sfs_setup_regs;
	logic                  clock, sys_rst, printer_mode_bit, lock_enable, programmed_density;
	logic                  baud_ref_tick, power_good_pin_in, game_port_select;
	logic                  second_drive_pin_in, extra_irq, second_density_out, shared_pin_out;
	logic                  shared_pin_oe_n, power_good_input, address_qual_pin;
	logic                  second_drive_pin_out, second_drive_pin_oe_n, second_drive_present;
	logic                  uart1_baud_tick, uart2_baud_tick;
	logic [7:0]            cfg_rdata, v;
	sfs_pkg::sfs_cfg_req_s cfg_req;
	sfs_pkg::sfs_setup_s   setup;
	int                    fail_count, total_checks, n1, n2;
	logic [7:0]            pins [4] = '{8'h00, 8'h05, 8'h81, 8'h84};

	sfs_setup_regs uut
	(
		.clock, .sys_rst, .cfg_req, .cfg_rdata, .printer_mode_bit, .lock_enable,
		.baud_ref_tick, .programmed_density, .second_density_out, .power_good_pin_in,
		.game_port_select, .shared_pin_out, .shared_pin_oe_n, .power_good_input,
		.second_drive_pin_in, .extra_irq, .address_qual_pin, .second_drive_pin_out,
		.second_drive_pin_oe_n, .second_drive_present, .uart1_baud_tick, .uart2_baud_tick,
		.setup
	);

	// ==========================================================
	// Clock, and a reference tick every other cycle
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock)
		baud_ref_tick <= ~baud_ref_tick;

	// ==========================================================
	// Helpers
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Write strobe for one cycle, then wait out the decode lag
	task automatic cfg_write(input logic [7:0] idx, input logic [7:0] data);
		@(posedge clock);
		cfg_req.config_index_reg <= idx;
		cfg_req.wdata <= data;
		cfg_req.wr <= 1'b1;
		@(posedge clock);
		cfg_req.wr <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask

	task automatic cfg_read(input logic [7:0] idx, input logic [7:0] exp);
		@(posedge clock);
		cfg_req.config_index_reg <= idx;
		cfg_req.rd <= 1'b1;
		@(posedge clock);
		cfg_req.rd <= 1'b0;
		#1;
		check("cfg_rdata", exp, cfg_rdata);
	endtask

	// Window of 312 cycles holds a whole number of either period
	task automatic count_ticks();
		n1 = 0;
		n2 = 0;
		repeat (312)
		begin
			@(posedge clock);
			#1;
			n1 += int'(uart1_baud_tick === 1'b1);
			n2 += int'(uart2_baud_tick === 1'b1);
		end
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog, well beyond the fewer than a thousand cycles needed
	initial
	begin
		repeat (20000) @(posedge clock);
		fail_count++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		{sys_rst, printer_mode_bit, lock_enable, game_port_select} = 4'hF;
		{baud_ref_tick, programmed_density, power_good_pin_in} = 3'h0;
		{second_drive_pin_in, extra_irq} = 2'h3;
		cfg_req = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		cfg_req.cfg_state <= 1'b1;
		cfg_read(8'h03, 8'h70);
		cfg_read(8'h04, 8'h00);
		cfg_write(8'h03, 8'hFF);
		cfg_read(8'h03, 8'hF7);
		cfg_write(8'h04, 8'hFF);
		cfg_read(8'h04, 8'h7F);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clock) programmed_density <= i[1];
			cfg_write(8'h03, {1'b0, i[1:0], i[0], 2'b00, ~i[0], 1'b0});
			check("floppy_if", {6'h00, i[1:0]}, {6'h00, setup.floppy_if});
			check("enh_floppy", {7'h00, ~i[0]}, {7'h00, setup.enhanced_floppy});
			check("density", {7'h00, i[0] | i[1]}, {7'h00, second_density_out});
		end
		// Pin levels change per step; the write gives the synchronisers time
		foreach (pins[k])
		begin
			v = pins[k];
			@(posedge clock) {power_good_pin_in, second_drive_pin_in, game_port_select, extra_irq}
				<= {k[1], ~k[0], k[0], ~k[0]};
			cfg_write(8'h03, v);
			check("shared_fn", {6'h00, v[7] & v[2], v[7] & ~v[2]}, {6'h00, setup.shared_fn});
			check("pin_out", {6'h00, ~k[0], k[0]},
				{6'h00, second_drive_pin_out, shared_pin_out});
			check("oe_n", {6'h00, ~(v[7] & v[2]), ~v[0]},
				{6'h00, second_drive_pin_oe_n, shared_pin_oe_n});
			check("pin_in", {5'h00, ~v[7] & ~k[0], v[7] & ~v[2] & ~k[0], v[0] | k[1]},
				{5'h00, second_drive_present, address_qual_pin, power_good_input});
		end
		@(posedge clock) printer_mode_bit <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			cfg_write(8'h04, {4'h0, i[1:0], ~i[1:0]});
			check("par_mode", {6'h00, ~i[1:0]}, {5'h00, setup.par_mode});
			check("port_floppy", {6'h00, i[1:0]}, {6'h00, setup.port_floppy});
		end
		@(posedge clock) printer_mode_bit <= 1'b1;
		@(posedge clock);
		#1;
		check("par_mode", 8'h04, {5'h00, setup.par_mode});
		for (int k = 0; k < 2; k++)
		begin
			v = k ? 8'h20 : 8'h50;
			cfg_write(8'h04, v);
			repeat (60) @(posedge clock);
			count_ticks();
			check("uart1_ticks", v[4] ? 8'h0D : 8'h0C, n1[7:0]);
			check("uart2_ticks", v[5] ? 8'h0D : 8'h0C, n2[7:0]);
			check("epp_v17", {7'h00, v[6]}, {7'h00, setup.epp_v17});
		end
		// Refused accesses leave the register alone and read zero
		@(posedge clock) lock_enable <= 1'b0;
		cfg_write(8'h03, 8'h00);
		cfg_read(8'h03, 8'h00);
		@(posedge clock) lock_enable <= 1'b1;
		cfg_read(8'h03, 8'h84);
		@(posedge clock) cfg_req.cfg_state <= 1'b0;
		cfg_write(8'h03, 8'h00);
		cfg_read(8'h03, 8'h00);
		@(posedge clock) cfg_req.cfg_state <= 1'b1;
		cfg_read(8'h03, 8'h84);
		cfg_read(8'h05, 8'h00);
		report_and_stop();
	end
endmodule
